// [inc/rse_defines.vh]
// Constants for the rotate, subtract and sleep execution slice
// Functional notes
// RQ1: Rotate right via carry: old carry into bit 7, bit 0 into carry.
// RQ2: Rotate destination 0 to accumulator, 1 to file; only carry changes.
// RQ3: Literal minus accumulator into accumulator; updates all three flags.
// RQ4: Carry 0 if subtrahend exceeds minuend; digit carry same on low nibble.
// RQ5: File register minus accumulator; updates carry, digit carry and zero.
// RQ6: Register subtract destination 0 to accumulator, 1 to file register.
// RQ7: Subtract with borrow also takes inverted carry off the difference.
// RQ8: Borrow subtract destination 0 to accumulator, 1 to file register.
// RQ9: Sleep clears the watchdog counter and its prescaler.
// RQ10: Sleep drives the power-down status bit low.
// RQ11: Sleep drives the time-out status bit high.
// RQ12: After sleep the core halts with its oscillator stopped.
// RQ13: Zero flag set when the 8-bit subtract result is zero, else cleared.
`ifndef RSE_DEFINES_VH
`define RSE_DEFINES_VH

// Instruction codes on the issue port
`define RSE_OP_NOP          3'h0
`define RSE_OP_ROT_RIGHT    3'h1
`define RSE_OP_LIT_SUB      3'h2
`define RSE_OP_REG_SUB      3'h3
`define RSE_OP_REG_SUB_BRW  3'h4
`define RSE_OP_SLEEP        3'h5

// Register port map
`define RSE_ADDR_FILE_LAST  8'h7f
`define RSE_ADDR_ACC        8'h80
`define RSE_ADDR_STATUS     8'h81
`define RSE_ADDR_WDOG       8'h82
`define RSE_ADDR_CTRL       8'h83

// Status field positions
`define RSE_ST_CARRY        0
`define RSE_ST_DIGIT        1
`define RSE_ST_ZERO         2
`define RSE_ST_PWRDN_N      3
`define RSE_ST_TMOUT_N      4
`define RSE_ST_ASLEEP       5

// Control field positions
`define RSE_CTRL_WDOG_EN    0

// Reset values
`define RSE_RST_ACC         8'h00
`define RSE_RST_FILE        8'h00
`define RSE_RST_FLAG        1'h0
`define RSE_RST_PWRDN_N     1'h1
`define RSE_RST_TMOUT_N     1'h1
`define RSE_RST_WDOG_EN     1'h0
`define RSE_WDOG_CLEAR      8'h00

`endif

// [rtl/rse_sub_alu.v]
// Subtract unit: minuend minus subtrahend minus borrow, with flags
module rse_sub_alu #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] minuend,
  input  wire [WIDTH-1:0] subtrahend,
  input  wire             borrow_in,
  output wire [WIDTH-1:0] diff,
  output wire             carry_out,
  output wire             digit_out,
  output wire             zero_out
);

  wire [WIDTH:0] full_sum;
  wire [4:0]     nib_sum;
  wire           carry_in;

  // Add of inverted subtrahend keeps carry equal to no-borrow
  assign carry_in  = ~borrow_in; // RQ7
  assign full_sum  = {1'b0, minuend} + {1'b0, ~subtrahend}
                   + {{WIDTH{1'b0}}, carry_in}; // RQ3 RQ5
  assign nib_sum   = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                   + {4'h0, carry_in};
  assign diff      = full_sum[WIDTH-1:0];
  assign carry_out = full_sum[WIDTH]; // RQ4
  assign digit_out = nib_sum[4]; // RQ4
  assign zero_out  = (full_sum[WIDTH-1:0] == {WIDTH{1'b0}}); // RQ13

endmodule

// [rtl/rse_exec.v]
// Execution core for rotate, subtract and sleep with register port
`include "rse_defines.vh"

module rse_exec #(
  parameter FILE_DEPTH  = 128,
  parameter FADDR_W     = 7,
  parameter PRESCALE_W  = 12,
  parameter WDOG_W      = 8
) (
  input  wire               clk,
  input  wire               reset,
  // Instruction issue
  input  wire               instr_valid,
  input  wire [2:0]         instr_op,
  input  wire               instr_dest,
  input  wire [FADDR_W-1:0] instr_faddr,
  input  wire [7:0]         instr_lit,
  output wire               instr_ready,
  // Register port
  input  wire [7:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [7:0]         reg_rdata,
  // Sleep and watchdog
  input  wire               wake_pin,
  output reg                osc_run,
  output reg                wdog_timeout
);

  ////////////////////////////////////////////////////////////////////
  // State

  reg  [7:0]            acc;
  reg  [7:0]            file_mem [0:FILE_DEPTH-1];
  reg                   carry_flag;
  reg                   digit_carry_flag;
  reg                   zero_flag;
  reg                   powerdown_status_n;
  reg                   timeout_status_n;
  reg                   asleep;
  reg                   wdog_en;
  reg  [PRESCALE_W-1:0] wdog_prescale;
  reg  [WDOG_W-1:0]     watchdog_counter;

  // Wake pin synchroniser, three stages
  reg                   wake_s1;
  reg                   wake_s2;
  reg                   wake_s3;
  reg                   wake_level;

  ////////////////////////////////////////////////////////////////////
  // Instruction decode

  wire                  take;
  wire [7:0]            file_rd;
  wire                  op_rot;
  wire                  op_lsub;
  wire                  op_rsub;
  wire                  op_bsub;
  wire                  op_sleep;
  wire                  op_any_sub;

  // No new work is taken once the clock would be stopped
  assign instr_ready = ~asleep; // RQ12
  assign take        = instr_valid & ~asleep;
  assign file_rd     = file_mem[instr_faddr];

  assign op_rot     = take & (instr_op == `RSE_OP_ROT_RIGHT);
  assign op_lsub    = take & (instr_op == `RSE_OP_LIT_SUB);
  assign op_rsub    = take & (instr_op == `RSE_OP_REG_SUB);
  assign op_bsub    = take & (instr_op == `RSE_OP_REG_SUB_BRW);
  assign op_sleep   = take & (instr_op == `RSE_OP_SLEEP);
  assign op_any_sub = op_lsub | op_rsub | op_bsub;

  ////////////////////////////////////////////////////////////////////
  // Datapath

  wire [7:0] sub_a;
  wire [7:0] sub_b;
  wire       sub_brw;
  wire [7:0] sub_res;
  wire       sub_c;
  wire       sub_dc;
  wire       sub_z;
  wire [7:0] rot_res;

  assign sub_a   = op_lsub ? instr_lit : file_rd; // RQ3 RQ5
  assign sub_b   = acc;
  // Borrow is the inverted carry, only for the borrow form
  assign sub_brw = op_bsub & ~carry_flag; // RQ7

  rse_sub_alu #(
    .WIDTH      (8)
  ) u_sub (
    .minuend    (sub_a),
    .subtrahend (sub_b),
    .borrow_in  (sub_brw),
    .diff       (sub_res),
    .carry_out  (sub_c),
    .digit_out  (sub_dc),
    .zero_out   (sub_z)
  );

  assign rot_res = {carry_flag, file_rd[7:1]}; // RQ1

  reg  [7:0] next_result;
  reg        next_to_acc;
  reg        next_to_file;

  always @* begin
    next_result  = 8'h00;
    next_to_acc  = 1'b0;
    next_to_file = 1'b0;
    case (1'b1)
      op_rot: begin
        next_result  = rot_res;
        next_to_acc  = ~instr_dest; // RQ2
        next_to_file = instr_dest; // RQ2
      end
      op_lsub: begin
        next_result  = sub_res;
        next_to_acc  = 1'b1; // RQ3
      end
      op_rsub: begin
        next_result  = sub_res;
        next_to_acc  = ~instr_dest; // RQ6
        next_to_file = instr_dest; // RQ6
      end
      op_bsub: begin
        next_result  = sub_res;
        next_to_acc  = ~instr_dest; // RQ8
        next_to_file = instr_dest; // RQ8
      end
      default: begin
        next_result  = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Register port decode

  wire       bus_file;
  wire       wr_acc;
  wire       wr_status;
  wire       wr_wdog;
  wire       wr_ctrl;
  wire [7:0] status_view;

  assign bus_file  = (reg_addr <= `RSE_ADDR_FILE_LAST);
  assign wr_acc    = reg_wr & (reg_addr == `RSE_ADDR_ACC);
  assign wr_status = reg_wr & (reg_addr == `RSE_ADDR_STATUS);
  assign wr_wdog   = reg_wr & (reg_addr == `RSE_ADDR_WDOG);
  assign wr_ctrl   = reg_wr & (reg_addr == `RSE_ADDR_CTRL);

  assign status_view = {2'h0, asleep, timeout_status_n,
                        powerdown_status_n, zero_flag,
                        digit_carry_flag, carry_flag};

  ////////////////////////////////////////////////////////////////////
  // File registers
  // An instruction write beats a port write to the same entry

  genvar gi;
  generate
    for (gi = 0; gi < FILE_DEPTH; gi = gi + 1) begin : g_file
      always @(posedge clk) begin
        if (reset) begin
          file_mem[gi] <= `RSE_RST_FILE;
        end else if (next_to_file && instr_faddr == gi) begin
          file_mem[gi] <= next_result; // RQ2 RQ6 RQ8
        end else if (reg_wr && bus_file && reg_addr == gi) begin
          file_mem[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Accumulator and arithmetic flags

  always @(posedge clk) begin
    if (reset) begin
      acc <= `RSE_RST_ACC;
    end else if (next_to_acc) begin
      acc <= next_result; // RQ2 RQ3 RQ6 RQ8
    end else if (wr_acc) begin
      acc <= reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      carry_flag       <= `RSE_RST_FLAG;
      digit_carry_flag <= `RSE_RST_FLAG;
      zero_flag        <= `RSE_RST_FLAG;
    end else if (op_rot) begin
      // Rotate leaves digit carry and zero alone
      carry_flag       <= file_rd[0]; // RQ1 RQ2
    end else if (op_any_sub) begin
      carry_flag       <= sub_c; // RQ4
      digit_carry_flag <= sub_dc; // RQ4
      zero_flag        <= sub_z; // RQ13
    end else if (wr_status) begin
      carry_flag       <= reg_wdata[`RSE_ST_CARRY];
      digit_carry_flag <= reg_wdata[`RSE_ST_DIGIT];
      zero_flag        <= reg_wdata[`RSE_ST_ZERO];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wake pin synchroniser

  always @(posedge clk) begin
    if (reset) begin
      wake_s1    <= 1'b0;
      wake_s2    <= 1'b0;
      wake_s3    <= 1'b0;
      wake_level <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      // Level only moves once two late stages agree
      if (wake_s2 == wake_s3) begin
        wake_level <= wake_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Watchdog
  // Keeps counting in sleep, as it runs from clk through its own prescaler

  wire presc_wrap;
  wire wdog_wrap;

  assign presc_wrap = wdog_en & (&wdog_prescale);
  assign wdog_wrap  = presc_wrap & (&watchdog_counter);

  always @(posedge clk) begin
    if (reset) begin
      wdog_prescale    <= {PRESCALE_W{1'b0}};
      watchdog_counter <= `RSE_WDOG_CLEAR;
    end else if (op_sleep || wr_wdog) begin
      wdog_prescale    <= {PRESCALE_W{1'b0}}; // RQ9
      watchdog_counter <= `RSE_WDOG_CLEAR; // RQ9
    end else if (wdog_en) begin
      wdog_prescale <= wdog_prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      if (presc_wrap) begin
        watchdog_counter <= watchdog_counter
                          + {{(WDOG_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wdog_en <= `RSE_RST_WDOG_EN;
    end else if (wr_ctrl) begin
      wdog_en <= reg_wdata[`RSE_CTRL_WDOG_EN];
    end
  end

  // Awake overflow asks the system for a reset; asleep it only wakes
  always @(posedge clk) begin
    if (reset) begin
      wdog_timeout <= 1'b0;
    end else begin
      wdog_timeout <= wdog_wrap & ~asleep & ~op_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power status and sleep state

  always @(posedge clk) begin
    if (reset) begin
      powerdown_status_n <= `RSE_RST_PWRDN_N;
      timeout_status_n   <= `RSE_RST_TMOUT_N;
    end else if (op_sleep) begin
      powerdown_status_n <= 1'b0; // RQ10
      timeout_status_n   <= 1'b1; // RQ11
    end else if (wdog_wrap) begin
      timeout_status_n   <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      asleep  <= 1'b0;
      osc_run <= 1'b1;
    end else if (op_sleep) begin
      asleep  <= 1'b1; // RQ12
      osc_run <= 1'b0; // RQ12
    end else if (asleep && (wake_level || wdog_wrap)) begin
      asleep  <= 1'b0;
      osc_run <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the strobe

  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (bus_file) begin
        reg_rdata <= file_mem[reg_addr[FADDR_W-1:0]];
      end else begin
        case (reg_addr)
          `RSE_ADDR_ACC:    reg_rdata <= acc;
          `RSE_ADDR_STATUS: reg_rdata <= status_view;
          `RSE_ADDR_WDOG:   reg_rdata <= watchdog_counter;
          `RSE_ADDR_CTRL:   reg_rdata <= {7'h00, wdog_en};
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// [tb/rse_exec_checker.sv]
// Port-level assertions for the rotate, subtract and sleep slice
module rse_exec_checker #(
  parameter FADDR_W = 7
) (
  input wire               clk,
  input wire               reset,
  input wire               instr_valid,
  input wire [2:0]         instr_op,
  input wire               instr_dest,
  input wire [FADDR_W-1:0] instr_faddr,
  input wire [7:0]         instr_lit,
  input wire               instr_ready,
  input wire [7:0]         reg_addr,
  input wire [7:0]         reg_wdata,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [7:0]         reg_rdata,
  input wire               wake_pin,
  input wire               osc_run,
  input wire               wdog_timeout
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire sleep_go = instr_valid && instr_ready && instr_op == 3'h5;
  wire rd_st    = reg_rd && reg_addr == 8'h81;
  ////////////////////////////////////////////////////////////////
  property p_reset_idle;
    disable iff (1'b0) reset |=> instr_ready && osc_run &&
      reg_rdata == 8'h00 && !wdog_timeout;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset state");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
  property p_lit_acc;
    logic [7:0] w, k;
    (reg_wr && reg_addr == 8'h80, w = reg_wdata) ##1
    (instr_valid && instr_ready && instr_op == 3'h2, k = instr_lit)
    ##[1:2] (reg_rd && reg_addr == 8'h80) |=> reg_rdata == k - w;
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("literal diff");
  property p_lit_flags;
    logic [7:0] w, k;
    (reg_wr && reg_addr == 8'h80, w = reg_wdata) ##1
    (instr_valid && instr_ready && instr_op == 3'h2, k = instr_lit) ##1
    rd_st |=> reg_rdata[2:0] == {k == w, w[3:0] <= k[3:0], w <= k};
  endproperty
  a_lit_flags: assert property (p_lit_flags) else $error("flags");
  property p_sleep_halt;
    sleep_go |=> !osc_run && !instr_ready;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("no halt");
  property p_sleep_stays;
    sleep_go ##1 (!wake_pin) [*3] |-> !instr_ready && !osc_run;
  endproperty
  a_sleep_stays: assert property (p_sleep_stays) else $error("woke");
  property p_pwrdn_low;
    rd_st && !instr_ready |=> !reg_rdata[3] && reg_rdata[5];
  endproperty
  a_pwrdn_low: assert property (p_pwrdn_low) else $error("powerdown");
  property p_tmout_high;
    sleep_go ##1 rd_st |=> reg_rdata[4];
  endproperty
  a_tmout_high: assert property (p_tmout_high) else $error("timeout");
  property p_wdog_clr;
    sleep_go ##[1:2] (reg_rd && reg_addr == 8'h82) |=> reg_rdata == 8'h00;
  endproperty
  a_wdog_clr: assert property (p_wdog_clr) else $error("wdog kept");
endmodule

bind rse_exec rse_exec_checker #(.FADDR_W(FADDR_W)) chk_i (
  .clk(clk), .reset(reset), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_dest(instr_dest),
  .instr_faddr(instr_faddr), .instr_lit(instr_lit),
  .instr_ready(instr_ready), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wake_pin(wake_pin), .osc_run(osc_run),
  .wdog_timeout(wdog_timeout));

// [tb/rse_exec_test.sv]
// Self-checking bench for the rotate, subtract and sleep slice
module rse_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'h0;
  logic       reset = 1'h1;
  logic       instr_valid = 1'h0;
  logic [2:0] instr_op = 3'h0;
  logic       instr_dest = 1'h0;
  logic [6:0] instr_faddr = 7'h00;
  logic [7:0] instr_lit = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic       wake_pin = 1'h0;
  wire        instr_ready;
  wire  [7:0] reg_rdata;
  wire        osc_run;
  wire        wdog_timeout;
  int         err_total = 0;
  int         tests_run = 0;

  always #12.5 clk = ~clk;

  // Short prescaler keeps watchdog periods within a brief run
  rse_exec #(.PRESCALE_W(2)) dut (
    .clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_dest(instr_dest),
    .instr_faddr(instr_faddr), .instr_lit(instr_lit),
    .instr_ready(instr_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wake_pin(wake_pin), .osc_run(osc_run),
    .wdog_timeout(wdog_timeout));
  ////////////////////////////////////////////////////////////////
  task close_out;
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Every strobe is set each cycle so none is assigned twice per step
  task cyc(input logic w, input logic r, input logic v);
    reg_wr <= w;
    reg_rd <= r;
    instr_valid <= v;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    cyc(1'h1, 1'h0, 1'h0);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    cyc(1'h0, 1'h1, 1'h0);
    #1 chk(reg_rdata, e);
  endtask
  task ex(input logic [2:0] op, input logic d, input logic [6:0] fa,
          input logic [7:0] k);
    instr_op <= op;
    instr_dest <= d;
    instr_faddr <= fa;
    instr_lit <= k;
    cyc(1'h0, 1'h0, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(8'h80, 8'h00);
    rdc(8'h81, 8'h18);
    rdc(8'h82, 8'h00);
    rdc(8'h83, 8'h00);
    wr(8'h81, 8'hff);
    rdc(8'h81, 8'h1f);
    wr(8'h90, 8'h55);
    rdc(8'h90, 8'h00);
  endtask
  task lsub(input logic [7:0] w, input logic [7:0] k);
    wr(8'h80, w);
    ex(3'h2, 1'h1, 7'h00, k);
    rdc(8'h81, {5'h03, k == w, w[3:0] <= k[3:0], w <= k});
    rdc(8'h80, k - w);
  endtask
  task rsub(input logic [2:0] op, input logic d, input logic [7:0] f,
            input logic [7:0] w, input logic c);
    logic [8:0] full;
    logic       b;
    logic       dig;
    b = (op == 3'h4) ? !c : 1'h0;
    full = {1'h0, f} - {1'h0, w} - {8'h00, b};
    dig = {1'h0, f[3:0]} >= {1'h0, w[3:0]} + {4'h0, b};
    wr(8'h81, {7'h00, c});
    wr(8'h7f, f);
    wr(8'h80, w);
    ex(op, d, 7'h7f, 8'h00);
    rdc(8'h81, {5'h03, full[7:0] == 8'h00, dig, !full[8]});
    rdc(d ? 8'h7f : 8'h80, full[7:0]);
    rdc(d ? 8'h80 : 8'h7f, d ? w : f);
  endtask
  task rot(input logic d, input logic [7:0] f, input logic c);
    wr(8'h81, {5'h00, 2'h3, c});
    wr(8'h00, f);
    ex(3'h1, d, 7'h00, 8'h00);
    rdc(8'h81, {5'h03, 2'h3, f[0]});
    rdc(d ? 8'h00 : 8'h80, {c, f[7:1]});
    if (!d) rdc(8'h00, f);
  endtask
  task t_sub;
    lsub(8'h03, 8'h05);
    lsub(8'h05, 8'h03);
    lsub(8'h0f, 8'h10);
    lsub(8'h77, 8'h77);
    lsub(8'h00, 8'hff);
    rsub(3'h3, 1'h0, 8'h40, 8'h41, 1'h0);
    rsub(3'h3, 1'h1, 8'h22, 8'h22, 1'h0);
    rsub(3'h4, 1'h0, 8'h10, 8'h0f, 1'h0);
    rsub(3'h4, 1'h1, 8'h10, 8'h0f, 1'h1);
    rsub(3'h4, 1'h1, 8'h00, 8'h00, 1'h0);
  endtask
  task t_rot;
    rot(1'h0, 8'he6, 1'h0);
    rot(1'h1, 8'h01, 1'h1);
    rot(1'h1, 8'h80, 1'h0);
  endtask
  // Runs before sleep so the time-out bit starts low there
  task t_wdog;
    int n;
    wr(8'h81, 8'h00);
    wr(8'h83, 8'h01);
    wr(8'h82, 8'h00);
    n = 0;
    while (wdog_timeout !== 1'h1 && n < 1100) begin
      cyc(1'h0, 1'h0, 1'h0);
      #1 n++;
    end
    // Clear, then 256 counts of a four-cycle prescaler
    chk({7'h00, n == 4 * 256}, 8'h01);
    cyc(1'h0, 1'h0, 1'h0);
    #1 chk({7'h00, wdog_timeout}, 8'h00);
    rdc(8'h81, 8'h08);
    wr(8'h83, 8'h00);
  endtask
  task t_sleep;
    int n;
    wr(8'h83, 8'h01);
    wr(8'h81, 8'h00);
    wr(8'h80, 8'h5a);
    repeat (10) cyc(1'h0, 1'h0, 1'h0);
    ex(3'h5, 1'h0, 7'h00, 8'h00);
    rdc(8'h81, 8'h30);
    chk({7'h00, osc_run}, 8'h00);
    rdc(8'h82, 8'h00);
    ex(3'h2, 1'h0, 7'h00, 8'h00);
    #1 chk({7'h00, instr_ready}, 8'h00);
    wake_pin <= 1'h1;
    cyc(1'h0, 1'h0, 1'h0);
    n = 0;
    while (instr_ready !== 1'h1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, instr_ready}, 8'h01);
    chk({7'h00, osc_run}, 8'h01);
    wake_pin <= 1'h0;
    wr(8'h83, 8'h00);
    rdc(8'h80, 8'h5a);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    err_total++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_reset;
    t_sub;
    t_rot;
    t_wdog;
    t_sleep;
    cyc(1'h0, 1'h0, 1'h0);
    close_out;
  end
endmodule
